// ### tdts_pkg.sv
package tdts_pkg;

	// Sample and vector widths
	localparam int SAMPLE_W = 16;
	localparam int DOT_W    = 2 * SAMPLE_W + 2;
	localparam int TS_W     = 24;
	localparam int ADDR_W   = 7;

	typedef struct packed
	{
		logic signed [SAMPLE_W-1:0] x;
		logic signed [SAMPLE_W-1:0] y;
		logic signed [SAMPLE_W-1:0] z;
	} tdts_accel_type;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
		logic              wr;
		logic              rd;
	} tdts_bus_type;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_TEN = 7'h19;
	localparam logic [ADDR_W-1:0] ADDR_FEATURE_CFG = 7'h58;
	localparam logic [ADDR_W-1:0] ADDR_WAKE_DUR    = 7'h5c;
	localparam logic [ADDR_W-1:0] ADDR_PIN1_ROUTE  = 7'h5e;
	localparam logic [ADDR_W-1:0] ADDR_PIN2_ROUTE  = 7'h5f;
	localparam logic [ADDR_W-1:0] ADDR_FUNCTION_SOURCE_REG    = 7'h53;
	localparam logic [ADDR_W-1:0] ADDR_TS_LOW      = 7'h40;
	localparam logic [ADDR_W-1:0] ADDR_TS_MID      = 7'h41;
	localparam logic [ADDR_W-1:0] ADDR_TS_HIGH     = 7'h42;

	// Field positions
	localparam int BIT_EMBEDDED_FUNC_ENABLE     = 2;
	localparam int BIT_TIMER_EN    = 7;
	localparam int BIT_TILT_EN     = 5;
	localparam int BIT_LATCH       = 0;
	localparam int BIT_TS_HR       = 4;
	localparam int BIT_ROUTE_TILT  = 1;
	localparam int BIT_ROUTE_TIMER = 0;
	localparam int BIT_SRC_TILT    = 5;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] TS_CLEAR_KEY = 8'haa;
	localparam logic [TS_W-1:0] TS_MAX = 24'hffffff;
	localparam logic [TS_W-1:0] TS_END_VALUE = 24'hffff00;

	// Tilt threshold: cos^2(35 deg) scaled by 1024
	localparam int TILT_ANGLE_DEG = 35;
	localparam logic [11:0] TILT_COS_SQ_NUM = 12'h2af;
	localparam logic [11:0] TILT_COS_SQ_DEN = 12'h400;

	// Timing
	localparam int CLK_PERIOD_NS  = 100;
	localparam int BASE_TICK_NS   = 25000;
	localparam int LR_TICK_NS     = 6400000;
	localparam int EVAL_RATE_HZ   = 26;
	localparam int PIN_PULSE_NS   = 60000;
	localparam int TILT_PERSIST_MS = 2000;
	localparam int BASE_TICK_CYC  = BASE_TICK_NS / CLK_PERIOD_NS;
	localparam int LR_TICKS       = LR_TICK_NS / BASE_TICK_NS;
	localparam int EVAL_TICKS     = 1000000000 / (EVAL_RATE_HZ * BASE_TICK_NS);
	localparam int PIN_PULSE_CYC  = PIN_PULSE_NS / CLK_PERIOD_NS;
	localparam int PERSIST_EVALS  = TILT_PERSIST_MS * EVAL_RATE_HZ / 1000;

	typedef enum logic [1:0]
	{
		TILT_OFF,
		TILT_CAPTURE,
		TILT_FIRST,
		TILT_RUN
	} tdts_tilt_state_type;

endpackage : tdts_pkg

// ### tdts_dot3.sv
`timescale 1ns/1ps
module tdts_dot3 (
	// Operand vectors
	input  wire tdts_pkg::tdts_accel_type    vecA,
	input  wire tdts_pkg::tdts_accel_type    vecB,
	// Signed dot product
	output logic signed [tdts_pkg::DOT_W-1:0] dot
);
	import tdts_pkg::*;

	always_comb
	begin
		// Widen before multiplying so no product is cut to 16 bits
		dot = DOT_W'(vecA.x) * DOT_W'(vecB.x)
			+ DOT_W'(vecA.y) * DOT_W'(vecB.y)
			+ DOT_W'(vecA.z) * DOT_W'(vecB.z);
	end

endmodule : tdts_dot3

// ### tdts_core.sv
// Contract
// [R1] Host sets function and tilt enables first
// [R2] Tilt event when angle exceeds 35 degrees
// [R3] Start position captured at enable, each event
// [R4] First event needs 2 s continuous tilt
// [R5] Later events fire immediately, no persistence
// [R6] Event routable to either pin, flag visible
// [R7] Unlatched: 60 us pin pulse, flag one period
// [R8] Latched and routed: source read clears, re-arms
// [R9] Latched unrouted: flag pulses one period
// [R10] Host keeps accelerometer rate at 26 Hz+
// [R11] Counter stops when both sensors powered down
// [R12] 24-bit count readable as three bytes
// [R13] Tick 6.4 ms low res, 25 us high
// [R14] Low resolution wraps to zero at maximum
// [R15] High resolution saturates at maximum
// [R16] Writing key to high byte clears counter
// [R17] Timer-end event at FFFF00, routable pin one
// [R18] Timer-end pin held until key written
// [R19] Count offered to buffer as third set
// [R20] One time base for all ticks
`timescale 1ns/1ps
module tdts_core #(
	parameter int EVAL_TICKS_P = tdts_pkg::EVAL_TICKS
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	// Register port
	input  wire tdts_pkg::tdts_bus_type   regBus,
	output logic [7:0]                    regRdData,
	// Accelerometer side
	input  wire tdts_pkg::tdts_accel_type accelSample,
	input  wire logic                     accelValid,
	input  wire logic                     accelPowerDown,
	input  wire logic                     gyroPowerDown,
	// Interrupt pins
	output logic                          interruptPinOne,
	output logic                          interruptPinTwo,
	// Third data set for the buffer
	output logic [tdts_pkg::TS_W-1:0]     timestampCount
);
	import tdts_pkg::*;

	localparam int PW = 2 * DOT_W + 12;
	localparam logic [7:0] BASE_LAST = 8'(BASE_TICK_CYC - 1);
	localparam logic [7:0] LR_LAST = 8'(LR_TICKS - 1);
	localparam logic [10:0] EVAL_LAST = 11'(EVAL_TICKS_P - 1);
	localparam logic [9:0] PULSE_LOAD = 10'(PIN_PULSE_CYC);
	localparam logic [5:0] PERSIST_LAST = 6'(PERSIST_EVALS - 1);

	// Software-visible registers
	logic [7:0]          control_ten_reg;
	logic [7:0]          featureCfg;
	logic [7:0]          wake_duration_reg;
	logic [7:0]          pin1_routing_reg;
	logic [7:0]          pin2_routing_reg;

	// Decoded controls
	logic                embedded_func_enable;
	logic                tiltEnable;
	logic                timerEnable;
	logic                latch_interrupt_select;
	logic                timestamp_high_res;
	logic                tilt_route_pin1;
	logic                tilt_route_pin2;
	logic                timer_end_route_pin1;

	// Bus decode
	logic                wrHit;
	logic                srcRead;
	logic                clearWrite;

	// Time base
	logic [7:0]          baseCnt;
	logic [10:0]         evalCnt;
	logic [7:0]          lrCnt;
	logic                baseTick;
	logic                evalTick;

	// Time stamp
	logic                tsRun;
	logic                tsStep;
	logic                timerEndFlag;

	// Tilt
	tdts_tilt_state_type tiltState;
	tdts_accel_type      latestSample;
	tdts_accel_type      startVec;
	logic [5:0]          persistCnt;
	logic [9:0]          pulseCnt;
	logic                tilt_event_flag;
	logic                tiltActive;
	logic                holdMode;
	logic                detectHold;
	logic                tilted;
	logic                tiltFire;
	logic                tiltPinLevel;
	logic signed [DOT_W-1:0] dotSS;
	logic signed [DOT_W-1:0] dotCC;
	logic signed [DOT_W-1:0] dotSC;
	logic [PW-1:0]       lhs;
	logic [PW-1:0]       rhs;

	assign embedded_func_enable   = control_ten_reg[BIT_EMBEDDED_FUNC_ENABLE];
	assign tiltEnable             = featureCfg[BIT_TILT_EN];
	assign timerEnable            = featureCfg[BIT_TIMER_EN];
	assign latch_interrupt_select = featureCfg[BIT_LATCH];
	assign timestamp_high_res     = wake_duration_reg[BIT_TS_HR];
	assign tilt_route_pin1        = pin1_routing_reg[BIT_ROUTE_TILT];
	assign tilt_route_pin2        = pin2_routing_reg[BIT_ROUTE_TILT];
	assign timer_end_route_pin1   = pin1_routing_reg[BIT_ROUTE_TIMER];

	assign wrHit   = regBus.wr;
	assign srcRead = regBus.rd && (regBus.addr == ADDR_FUNCTION_SOURCE_REG);
	assign clearWrite = wrHit && (regBus.addr == ADDR_TS_HIGH)
		&& (regBus.data == TS_CLEAR_KEY); // [R16]

	// Configuration writes
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			control_ten_reg   <= REG_RESET;
			featureCfg        <= REG_RESET;
			wake_duration_reg <= REG_RESET;
			pin1_routing_reg  <= REG_RESET;
			pin2_routing_reg  <= REG_RESET;
		end
		else if (wrHit)
		begin
			case (regBus.addr)
				ADDR_CONTROL_TEN: control_ten_reg   <= regBus.data;
				ADDR_FEATURE_CFG: featureCfg        <= regBus.data;
				ADDR_WAKE_DUR:    wake_duration_reg <= regBus.data;
				ADDR_PIN1_ROUTE:  pin1_routing_reg  <= regBus.data;
				ADDR_PIN2_ROUTE:  pin2_routing_reg  <= regBus.data;
				default:          control_ten_reg   <= control_ten_reg;
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			regRdData <= REG_RESET;
		else if (regBus.rd)
		begin
			case (regBus.addr)
				ADDR_CONTROL_TEN: regRdData <= control_ten_reg;
				ADDR_FEATURE_CFG: regRdData <= featureCfg;
				ADDR_WAKE_DUR:    regRdData <= wake_duration_reg;
				ADDR_PIN1_ROUTE:  regRdData <= pin1_routing_reg;
				ADDR_PIN2_ROUTE:  regRdData <= pin2_routing_reg;
				ADDR_FUNCTION_SOURCE_REG:
					regRdData <= 8'(tilt_event_flag) << BIT_SRC_TILT; // [R6]
				ADDR_TS_LOW:  regRdData <= timestampCount[7:0];   // [R12]
				ADDR_TS_MID:  regRdData <= timestampCount[15:8];  // [R12]
				ADDR_TS_HIGH: regRdData <= timestampCount[23:16]; // [R12]
				default:      regRdData <= REG_RESET;
			endcase
		end
		else
			regRdData <= REG_RESET;
	end

	// Shared 25 us base; 26 Hz evaluation derived from it
	assign baseTick = (baseCnt == BASE_LAST); // [R20]
	assign evalTick = baseTick && (evalCnt == EVAL_LAST); // [R20]

	always_ff @(posedge sys_clk)
	begin
		if (rst || baseTick)
			baseCnt <= '0;
		else
			baseCnt <= baseCnt + 8'h01;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst || evalTick)
			evalCnt <= '0;
		else if (baseTick)
			evalCnt <= evalCnt + 11'h001;
	end

	// Time stamp counter
	assign tsRun = timerEnable && !(accelPowerDown && gyroPowerDown); // [R11]
	assign tsStep = tsRun && baseTick
		&& (timestamp_high_res || lrCnt == LR_LAST); // [R13]

	// Prescaler runs through 256 base ticks for 6.4 ms
	always_ff @(posedge sys_clk)
	begin
		if (rst || clearWrite)
			lrCnt <= '0;
		else if (tsRun && baseTick)
			lrCnt <= lrCnt + 8'h01;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst || clearWrite)
			timestampCount <= '0; // [R16]
		else if (tsStep)
		begin
			if (timestampCount != TS_MAX)
				timestampCount <= timestampCount + 24'h000001; // [R12]
			else if (timestamp_high_res)
				timestampCount <= TS_MAX; // [R15]
			else
				timestampCount <= '0; // [R14]
		end
	end

	// Sticky end flag; arrival wins over the clearing write
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			timerEndFlag <= 1'b0;
		else if (tsStep && timestampCount == TS_END_VALUE - 24'h000001)
			timerEndFlag <= 1'b1; // [R17]
		else if (clearWrite)
			timerEndFlag <= 1'b0; // [R18]
	end

	// Angle test without square roots: beyond 35 deg when
	// (s.c)^2 < cos^2 * |s|^2 |c|^2, or s.c not positive
	tdts_dot3 u_dotSS (
		.vecA (startVec),
		.vecB (startVec),
		.dot  (dotSS)
	);

	tdts_dot3 u_dotCC (
		.vecA (latestSample),
		.vecB (latestSample),
		.dot  (dotCC)
	);

	tdts_dot3 u_dotSC (
		.vecA (startVec),
		.vecB (latestSample),
		.dot  (dotSC)
	);

	always_comb
	begin
		lhs = PW'(dotSC) * PW'(dotSC) * PW'(TILT_COS_SQ_DEN);
		rhs = PW'(dotSS) * PW'(dotCC) * PW'(TILT_COS_SQ_NUM);
		tilted = (dotSC <= 0) || (lhs < rhs); // [R2]
	end

	assign tiltActive = embedded_func_enable && tiltEnable; // [R1]
	assign holdMode = latch_interrupt_select
		&& (tilt_route_pin1 || tilt_route_pin2);
	// Pending latched event blocks detection until read
	assign detectHold = holdMode && tilt_event_flag; // [R8]

	always_comb
	begin
		tiltFire = 1'b0;
		if (evalTick && tiltActive && tilted && !detectHold)
		begin
			case (tiltState)
				TILT_FIRST: tiltFire = (persistCnt == PERSIST_LAST); // [R4]
				TILT_RUN:   tiltFire = 1'b1; // [R5]
				default:    tiltFire = 1'b0;
			endcase
		end
	end

	// Evaluation trusts the newest sample to be fresh at 26 Hz
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			latestSample <= '0;
		else if (accelValid)
			latestSample <= accelSample; // [R10]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			tiltState <= TILT_OFF;
		else if (!tiltActive)
			tiltState <= TILT_OFF; // [R1]
		else
		begin
			case (tiltState)
				TILT_OFF:     tiltState <= TILT_CAPTURE;
				TILT_CAPTURE:
					if (evalTick)
						tiltState <= TILT_FIRST;
				TILT_FIRST:
					if (tiltFire)
						tiltState <= TILT_RUN; // [R5]
				TILT_RUN:     tiltState <= TILT_RUN;
				default:      tiltState <= TILT_OFF;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			startVec <= '0;
		else if (tiltState == TILT_CAPTURE && evalTick)
			startVec <= latestSample; // [R3]
		else if (tiltFire)
			startVec <= latestSample; // [R3]
	end

	// Any untilted evaluation restarts the 2 s window
	always_ff @(posedge sys_clk)
	begin
		if (rst || tiltState != TILT_FIRST)
			persistCnt <= '0;
		else if (evalTick)
		begin
			if (!tilted || tiltFire)
				persistCnt <= '0; // [R4]
			else if (persistCnt != PERSIST_LAST)
				persistCnt <= persistCnt + 6'h01; // [R4]
		end
	end

	// Source flag: new event beats a same-cycle clear
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			tilt_event_flag <= 1'b0;
		else if (tiltFire)
			tilt_event_flag <= 1'b1; // [R6]
		else if (holdMode)
		begin
			if (srcRead)
				tilt_event_flag <= 1'b0; // [R8]
		end
		else if (evalTick)
			tilt_event_flag <= 1'b0; // [R7] [R9]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			pulseCnt <= '0;
		else if (tiltFire && !holdMode)
			pulseCnt <= PULSE_LOAD; // [R7]
		else if (pulseCnt != '0)
			pulseCnt <= pulseCnt - 10'h001;
	end

	assign tiltPinLevel = holdMode ? tilt_event_flag : (pulseCnt != '0);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			interruptPinOne <= 1'b0;
			interruptPinTwo <= 1'b0;
		end
		else
		begin
			interruptPinOne <= (tilt_route_pin1 && tiltPinLevel) // [R6]
				|| (timer_end_route_pin1 && timerEndFlag); // [R17] [R18]
			interruptPinTwo <= tilt_route_pin2 && tiltPinLevel; // [R6]
		end
	end

	// timestampCount doubles as the buffer's third data set [R19]

endmodule : tdts_core

// ### tdts_core_props.sv
`timescale 1ns/1ps
module tdts_core_props
	import tdts_pkg::*;
(
	// Clock and reset
	input wire logic                   sys_clk,
	input wire logic                   rst,
	// Register port
	input wire tdts_pkg::tdts_bus_type regBus,
	input wire logic [7:0]             regRdData,
	// Sensor power
	input wire logic                   accelPowerDown,
	input wire logic                   gyroPowerDown,
	// Outputs
	input wire logic                   interruptPinOne,
	input wire logic                   interruptPinTwo,
	input wire logic [tdts_pkg::TS_W-1:0] timestampCount
);
	logic        latchSel;
	logic        tiltOne;
	logic        timerOne;
	logic [15:0] hiCnt;
	logic [7:0]  cntLow;
	logic        clrW;
	logic        srcRd;

	assign cntLow = timestampCount[7:0];
	assign clrW = regBus.wr && regBus.addr == ADDR_TS_HIGH
		&& regBus.data == TS_CLEAR_KEY;
	// Timer end shares pin one, so only the tilt-only level case
	assign srcRd = regBus.rd && regBus.addr == ADDR_FUNCTION_SOURCE_REG
		&& interruptPinOne && latchSel && tiltOne && !timerOne;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			latchSel <= 1'b0;
		else if (regBus.wr && regBus.addr == ADDR_FEATURE_CFG)
			latchSel <= regBus.data[BIT_LATCH];
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			tiltOne  <= 1'b0;
			timerOne <= 1'b0;
		end
		else if (regBus.wr && regBus.addr == ADDR_PIN1_ROUTE)
		begin
			tiltOne  <= regBus.data[BIT_ROUTE_TILT];
			timerOne <= regBus.data[BIT_ROUTE_TIMER];
		end
	end

	// Length of the current pin two pulse
	always_ff @(posedge sys_clk)
	begin
		if (rst || !interruptPinTwo)
			hiCnt <= 16'h0000;
		else
			hiCnt <= hiCnt + 16'h0001;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_rd_idle: assert property (
		!regBus.rd |=> regRdData == 8'h00)
		else $error("read data not zero outside read slot");
	chk_rd_unmapped: assert property (
		regBus.rd && regBus.addr == 7'h7f |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	chk_rd_count: assert property (
		regBus.rd && regBus.addr == ADDR_TS_LOW
		|=> regRdData == $past(cntLow))
		else $error("low count byte mismatch");
	chk_count_clear: assert property (
		clrW |=> timestampCount == 24'h000000)
		else $error("key write did not clear count");
	chk_count_frozen: assert property (
		accelPowerDown && gyroPowerDown && !clrW
		|=> $stable(timestampCount))
		else $error("count moved with both sensors down");
	chk_count_step: assert property (
		$changed(timestampCount) |-> timestampCount == 24'h000000
		|| timestampCount == $past(timestampCount) + 24'h000001)
		else $error("count jumped");
	chk_src_flag: assert property (
		srcRd |=> regRdData[BIT_SRC_TILT])
		else $error("tilt flag not seen with pin held");
	chk_src_clear: assert property (
		srcRd |-> ##2 !interruptPinOne)
		else $error("source read did not release pin");
	chk_pulse_width: assert property (
		$fell(interruptPinTwo) && !latchSel |-> hiCnt == PIN_PULSE_CYC)
		else $error("pin pulse width wrong");
endmodule : tdts_core_props

bind tdts_core tdts_core_props i_tdts_core_props (
	.sys_clk(sys_clk),
	.rst(rst),
	.regBus(regBus),
	.regRdData(regRdData),
	.accelPowerDown(accelPowerDown),
	.gyroPowerDown(gyroPowerDown),
	.interruptPinOne(interruptPinOne),
	.interruptPinTwo(interruptPinTwo),
	.timestampCount(timestampCount)
);

// ### tdts_accel_src.sv
`timescale 1ns/1ps
module tdts_accel_src
	import tdts_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// Orientation select
	input  wire logic                 tilted,
	// Sample stream
	output tdts_pkg::tdts_accel_type  accelSample,
	output logic                      accelValid
);
	logic [5:0] gap;

	// One sample each 50 cycles, far faster than the evaluation rate
	always_ff @(posedge sys_clk)
	begin
		if (rst || gap == 6'h31)
			gap <= 6'h00;
		else
			gap <= gap + 6'h01;
	end

	always_ff @(posedge sys_clk)
	begin
		accelValid <= !rst && gap == 6'h31;
		// 1 g on z at rest, on x when tilted: 90 degrees apart
		accelSample <= tilted ? 48'h4000_0000_0000 : 48'h0000_0000_4000;
	end
endmodule : tdts_accel_src

// ### tdts_core_tb.sv
`timescale 1ns/1ps
module tdts_core_tb;
	import tdts_pkg::*;

	logic            sysClk;
	logic            rst;
	tdts_bus_type    regBus;
	logic [7:0]      regRdData;
	tdts_accel_type  accelSample;
	logic            accelValid;
	logic            accelPowerDown;
	logic            gyroPowerDown;
	logic            interruptPinOne;
	logic            interruptPinTwo;
	logic [TS_W-1:0] timestampCount;
	logic            tilted;
	logic [7:0]      rdVal;
	logic            hit;
	int              badCount;
	int              checksDone;
	int              n;

	tdts_core #(.EVAL_TICKS_P(4)) i_tdts_core (
		.sys_clk(sysClk),
		.rst(rst),
		.regBus(regBus),
		.regRdData(regRdData),
		.accelSample(accelSample),
		.accelValid(accelValid),
		.accelPowerDown(accelPowerDown),
		.gyroPowerDown(gyroPowerDown),
		.interruptPinOne(interruptPinOne),
		.interruptPinTwo(interruptPinTwo),
		.timestampCount(timestampCount)
	);

	tdts_accel_src i_tdts_accel_src (
		.sys_clk(sysClk),
		.rst(rst),
		.tilted(tilted),
		.accelSample(accelSample),
		.accelValid(accelValid)
	);

	always #50 sysClk = ~sysClk;

	task summarize();
		if (badCount == 0 && checksDone > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task chk(input logic [23:0] seen, input logic [23:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			badCount++;
		end
	endtask : chk

	task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge sysClk);
		regBus.addr <= a;
		regBus.data <= d;
		regBus.wr   <= 1'b1;
		@(posedge sysClk);
		regBus.wr <= 1'b0;
	endtask : wr

	task rd(input logic [ADDR_W-1:0] a);
		@(posedge sysClk);
		regBus.addr <= a;
		regBus.rd   <= 1'b1;
		@(posedge sysClk);
		regBus.rd <= 1'b0;
		#1;
		rdVal = regRdData;
	endtask : rd

	// Bounded wait for pin one to reach a level
	task waitLvl(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (interruptPinOne !== lvl && cnt < lim)
		begin
			@(posedge sysClk);
			#1;
			cnt++;
		end
		if (interruptPinOne !== lvl)
		begin
			badCount++;
			summarize();
		end
	endtask : waitLvl

	initial
	begin
		sysClk = 1'b0;
		rst = 1'b1;
		regBus = '0;
		accelPowerDown = 1'b0;
		gyroPowerDown = 1'b0;
		tilted = 1'b0;
		badCount = 0;
		checksDone = 0;
		repeat (16) @(posedge sysClk);
		rst <= 1'b0;
		rd(ADDR_TS_LOW);
		chk(rdVal, 8'h00);
		rd(ADDR_FUNCTION_SOURCE_REG);
		chk(rdVal, 8'h00);
		rd(7'h7f);
		chk(rdVal, 8'h00);
		wr(ADDR_WAKE_DUR, 8'h10);
		wr(ADDR_FEATURE_CFG, 8'h80);
		wr(ADDR_TS_HIGH, TS_CLEAR_KEY);
		repeat (1100) @(posedge sysClk);
		rd(ADDR_TS_LOW);
		chk(rdVal, 8'h04);
		rd(ADDR_TS_MID);
		chk(rdVal, 8'h00);
		wr(ADDR_TS_HIGH, 8'h55);
		rd(ADDR_TS_LOW);
		chk(rdVal, 8'h04);
		accelPowerDown <= 1'b1;
		gyroPowerDown <= 1'b1;
		repeat (600) @(posedge sysClk);
		rd(ADDR_TS_LOW);
		chk(rdVal, 8'h04);
		chk(timestampCount, 24'h000004);
		accelPowerDown <= 1'b0;
		repeat (600) @(posedge sysClk);
		rd(ADDR_TS_LOW);
		chk(rdVal, 8'h07);
		gyroPowerDown <= 1'b0;
		wr(ADDR_TS_HIGH, TS_CLEAR_KEY);
		rd(ADDR_TS_LOW);
		chk(rdVal, 8'h00);
		wr(ADDR_CONTROL_TEN, 8'h04);
		wr(ADDR_PIN1_ROUTE, 8'h02);
		wr(ADDR_FEATURE_CFG, 8'ha1);
		repeat (1500) @(posedge sysClk);
		tilted <= 1'b1;
		hit = 1'b0;
		repeat (45000)
		begin
			@(posedge sysClk);
			#1;
			if (interruptPinOne !== 1'b0)
				hit = 1'b1;
		end
		chk(hit, 1'b0);
		waitLvl(1'b1, 12000, n);
		chk(interruptPinTwo, 1'b0);
		repeat (2000) @(posedge sysClk);
		chk(interruptPinOne, 1'b1);
		rd(ADDR_FUNCTION_SOURCE_REG);
		chk(rdVal, 8'h20);
		@(posedge sysClk);
		#1;
		chk(interruptPinOne, 1'b0);
		wr(ADDR_PIN2_ROUTE, 8'h02);
		wr(ADDR_FEATURE_CFG, 8'ha0);
		tilted <= 1'b0;
		waitLvl(1'b1, 2500, n);
		chk(interruptPinTwo, 1'b1);
		waitLvl(1'b0, 2000, n);
		chk(n, 600);
		rd(ADDR_FUNCTION_SOURCE_REG);
		chk(rdVal, 8'h20);
		repeat (1000) @(posedge sysClk);
		rd(ADDR_FUNCTION_SOURCE_REG);
		chk(rdVal, 8'h00);
		// Low resolution: a fresh prescaler needs 256 base ticks per step
		wr(ADDR_WAKE_DUR, 8'h00);
		wr(ADDR_TS_HIGH, TS_CLEAR_KEY);
		repeat (3000) @(posedge sysClk);
		rd(ADDR_TS_LOW);
		chk(rdVal, 8'h00);
		summarize();
	end
endmodule : tdts_core_tb
